/* File: core/uts_pkg.sv */
package uts_pkg;
	// Register byte offsets on the bus
	localparam logic [7:0] UTS_OFS_MODE0 = 8'h00;
	localparam logic [7:0] UTS_OFS_MODE1 = 8'h04;
	localparam logic [7:0] UTS_OFS_CTRL = 8'h08;
	localparam logic [7:0] UTS_OFS_BAUD = 8'h0C;
	localparam logic [7:0] UTS_OFS_STAT = 8'h10;
	localparam logic [7:0] UTS_OFS_BUF = 8'h14;
	// Field positions
	localparam int UTS_DIR_BIT = 0;
	localparam int UTS_RSEL_BIT = 4;
	localparam int UTS_EN_BIT = 0;
	localparam int UTS_FER_BIT = 0;
	localparam int UTS_OER_BIT = 1;
	localparam int UTS_PER_BIT = 2;
	localparam int UTS_FUL_BIT = 3;
	// Baud counter width, reset value and smallest effective count
	localparam int UTS_BAUD_W = 12;
	localparam logic [11:0] UTS_BAUD_RST = 12'h0FF;
	localparam logic [11:0] UTS_BAUD_MIN = 12'h007;
	localparam logic [7:0] UTS_CFG_RST = 8'h00;

	// Frame format, same layout as the mode 1 register
	typedef struct packed {
		logic msb_first;
		logic neg;
		logic stop2;
		logic odd;
		logic par_en;
		logic [1:0] len;
	} uts_frame_cfg_type;

	// Classic Wishbone request from the master
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [7:0] adr;
		logic [31:0] dat;
	} uts_wb_req_type;

	typedef enum logic [2:0] {
		T_IDLE = 3'b000, T_ARM = 3'b001, T_START = 3'b010,
		T_DATA = 3'b011, T_PAR = 3'b100, T_STOP = 3'b101
	} uts_tx_state_type;

	typedef enum logic [2:0] {
		R_IDLE = 3'b000, R_START = 3'b001, R_DATA = 3'b010,
		R_PAR = 3'b011, R_XFER = 3'b100, R_STOP = 3'b101
	} uts_rx_state_type;

	// Word length code 0..3 means 8..5 data bits
	function automatic logic [3:0] uts_data_bits(input logic [1:0] code);
		return 4'h8 - {2'b00, code};
	endfunction

	function automatic logic [7:0] uts_data_mask(input logic [1:0] code);
		return 8'hFF >> code;
	endfunction
endpackage

/* File: core/uts_baud_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module uts_baud_gen import uts_pkg::*; #(
	parameter int CW = UTS_BAUD_W
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic run,
	input wire logic restart,
	input wire logic [CW-1:0] limit,
	output logic fall_en,
	output logic rise_en
);
	logic [CW-1:0] cnt_reg;
	logic [CW-1:0] eff;
	logic [CW:0] half;

	if (CW < 4) begin : g_bad_width
		$error("uts_baud_gen: CW must be at least 4");
	end

	// Short counts behave as the minimum count
	always_comb begin
		eff = (limit < CW'(UTS_BAUD_MIN)) ? CW'(UTS_BAUD_MIN) : limit;
		half = ({1'b0, eff} + 1'b1) >> 1;
	end

	// Bit period counter, restarted to align the transfer clock
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_reg <= '0;
		end else if (!run || restart || cnt_reg >= eff) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end

	// Falling edge opens a bit, rising edge sits mid-bit
	assign fall_en = run && !restart && (cnt_reg == '0);
	assign rise_en = run && !restart && ({1'b0, cnt_reg} == half);
endmodule
`default_nettype wire

/* File: core/uts_rx_align.sv */
`timescale 1ns/1ps
`default_nettype none
module uts_rx_align import uts_pkg::*; (
	input wire logic [7:0] raw,
	input wire logic par_bit,
	input wire uts_frame_cfg_type cfg,
	output logic [7:0] word,
	output logic par_err
);
	// Right-align the shifted word and zero the unused upper bits
	always_comb begin
		if (cfg.msb_first) begin
			word = raw & uts_data_mask(cfg.len);
		end else begin
			word = raw >> cfg.len;
		end
		par_err = cfg.par_en && ((^word) ^ par_bit ^ cfg.odd);
	end
endmodule
`default_nettype wire

/* File: core/uts_top.sv */
// Local design decisions: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Short received words right-aligned, upper bits zero
// - Receive mode holds transmit line high
// - Transmit starts on enable with transmit direction
// - Enable starts baud transfer clock
// - Start, data, parity, stops from falling edges
// - Interrupt when each start bit goes out
// - Buffer write sets full; next word follows
// - Empty buffer: finish stop, clear enable, interrupt
// - Start bit detection restarts transfer clock
// - Rising edges sample data and parity
// - Word moves to buffer on next falling edge
// - Following rising edge: interrupt, stop/parity check
// - Detected errors set status flags
// - Sampling rising edge at bit centre
// - Reception repeats until enable cleared
// - Clearing enable at frame end keeps data
// - Any status write clears all flags
// - Overrun when unread word is overwritten
// - Frame 5-8 bits, parity, stops, order, polarity
// - Framing flag from start/stop, each reception
module uts_top import uts_pkg::*; (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire uts_wb_req_type wb_req,
	output logic wb_ack,
	output logic [31:0] wb_dat_o,
	input wire logic serial_rx_line0,
	input wire logic serial_rx_line1,
	output logic serial_tx_line,
	output logic serial_irq
);
	logic ack_reg;
	logic [31:0] dat_reg;
	logic dir_rx_reg;
	logic rsel_reg;
	uts_frame_cfg_type cfg_reg;
	logic en_reg;
	logic [11:0] baud_reg;
	logic fer_reg, oer_reg, per_reg, ful_reg;
	logic [7:0] buf_reg;
	logic unread_reg;
	logic irq_reg;
	logic line_reg;
	uts_tx_state_type tx_state_reg;
	logic [7:0] tx_word_reg;
	logic [3:0] tx_idx_reg;
	logic tx_stop2_reg;
	uts_rx_state_type rx_state_reg;
	logic [7:0] rx_sr_reg;
	logic [3:0] rx_idx_reg;
	logic rx_par_reg;
	logic rx_bad_start_reg;
	logic wb_hit, wb_do, wr, rd;
	logic wr_ctrl, wr_stat, wr_buf;
	logic [31:0] rd_data;
	logic fall_en, rise_en;
	logic tx_restart, rx_restart;
	logic [3:0] nbits;
	logic [7:0] dmask;
	logic tx_load, tx_irq, tx_done;
	logic tx_level;
	logic [2:0] tx_pos;
	logic rx_level, rx_xfer, rx_done;
	logic [7:0] rx_word;
	logic rx_par_err;

	assign nbits = uts_data_bits(cfg_reg.len);
	assign dmask = uts_data_mask(cfg_reg.len);

	// Bus decode: request seen, then committed on the ack cycle
	assign wb_hit = wb_req.cyc && wb_req.stb;
	assign wb_do = wb_hit && ack_reg;
	assign wr = wb_do && wb_req.we;
	assign rd = wb_do && !wb_req.we;
	assign wr_ctrl = wr && wb_req.sel[0] && (wb_req.adr == UTS_OFS_CTRL);
	assign wr_stat = wr && (wb_req.sel != 4'h0) && (wb_req.adr == UTS_OFS_STAT);
	assign wr_buf = wr && wb_req.sel[0] && (wb_req.adr == UTS_OFS_BUF);

	// Read view; error flags hide in transmit, full hides in receive
	always_comb begin
		rd_data = 32'h0000_0000;
		if (wb_req.adr == UTS_OFS_MODE0) begin
			rd_data[UTS_DIR_BIT] = dir_rx_reg;
			rd_data[UTS_RSEL_BIT] = rsel_reg;
		end else if (wb_req.adr == UTS_OFS_MODE1) begin
			rd_data[6:0] = cfg_reg;
		end else if (wb_req.adr == UTS_OFS_CTRL) begin
			rd_data[UTS_EN_BIT] = en_reg;
		end else if (wb_req.adr == UTS_OFS_BAUD) begin
			rd_data[11:0] = baud_reg;
		end else if (wb_req.adr == UTS_OFS_STAT) begin
			rd_data[UTS_FER_BIT] = fer_reg && dir_rx_reg;
			rd_data[UTS_OER_BIT] = oer_reg && dir_rx_reg;
			rd_data[UTS_PER_BIT] = per_reg && dir_rx_reg;
			rd_data[UTS_FUL_BIT] = ful_reg && !dir_rx_reg;
		end else if (wb_req.adr == UTS_OFS_BUF) begin
			rd_data[7:0] = buf_reg;
		end
	end

	// Ack one cycle after the request, dropped the cycle after
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= wb_hit && !ack_reg;
			if (wb_hit && !ack_reg) begin
				dat_reg <= rd_data;
			end
		end
	end

	// Mode, format and baud registers
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			dir_rx_reg <= 1'b0;
			rsel_reg <= 1'b0;
			cfg_reg <= uts_frame_cfg_type'(UTS_CFG_RST[6:0]);
			baud_reg <= UTS_BAUD_RST;
		end else if (wr) begin
			if (wb_req.adr == UTS_OFS_MODE0 && wb_req.sel[0]) begin
				dir_rx_reg <= wb_req.dat[UTS_DIR_BIT];
				rsel_reg <= wb_req.dat[UTS_RSEL_BIT];
			end
			if (wb_req.adr == UTS_OFS_MODE1 && wb_req.sel[0]) begin
				cfg_reg <= uts_frame_cfg_type'(wb_req.dat[6:0]);
			end
			if (wb_req.adr == UTS_OFS_BAUD) begin
				if (wb_req.sel[0]) begin
					baud_reg[7:0] <= wb_req.dat[7:0];
				end
				if (wb_req.sel[1]) begin
					baud_reg[11:8] <= wb_req.dat[11:8];
				end
			end
		end
	end

	// Enable: software write wins, transmitter clears it at the end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			en_reg <= 1'b0;
		end else if (wr_ctrl) begin
			en_reg <= wb_req.dat[UTS_EN_BIT];
		end else if (tx_done) begin
			en_reg <= 1'b0;
		end
	end

	// Transfer clock, paced by the programmed rate while enabled
	uts_baud_gen #(
		.CW(UTS_BAUD_W)
	) u_baud (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.run(en_reg),
		.restart(tx_restart || rx_restart),
		.limit(baud_reg),
		.fall_en(fall_en),
		.rise_en(rise_en)
	);

	// Transmit bit selection in the chosen order
	always_comb begin
		tx_pos = cfg_reg.msb_first ? 3'(nbits - 4'h1 - tx_idx_reg) : tx_idx_reg[2:0];
		case (tx_state_reg)
			T_START: tx_level = 1'b0;
			T_DATA: tx_level = tx_word_reg[tx_pos];
			T_PAR: tx_level = (^(tx_word_reg & dmask)) ^ cfg_reg.odd;
			default: tx_level = 1'b1;
		endcase
	end

	assign tx_restart = en_reg && !dir_rx_reg && (tx_state_reg == T_IDLE);
	assign tx_load = fall_en && ((tx_state_reg == T_ARM) ||
		(tx_state_reg == T_STOP && !(cfg_reg.stop2 && !tx_stop2_reg) && ful_reg));
	assign tx_done = fall_en && tx_state_reg == T_STOP &&
		!(cfg_reg.stop2 && !tx_stop2_reg) && !ful_reg;
	assign tx_irq = tx_load || tx_done;

	// Transmit sequencer, one step per transfer clock falling edge
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_state_reg <= T_IDLE;
			tx_word_reg <= 8'h00;
			tx_idx_reg <= 4'h0;
			tx_stop2_reg <= 1'b0;
		end else if (!en_reg || dir_rx_reg) begin
			tx_state_reg <= T_IDLE;
		end else begin
			case (tx_state_reg)
				T_IDLE: tx_state_reg <= T_ARM;
				T_ARM: begin
					if (fall_en) begin
						tx_state_reg <= T_START;
					end
				end
				T_START: begin
					if (fall_en) begin
						tx_state_reg <= T_DATA;
						tx_idx_reg <= 4'h0;
					end
				end
				T_DATA: begin
					if (fall_en) begin
						tx_idx_reg <= tx_idx_reg + 4'h1;
						if (tx_idx_reg == nbits - 4'h1) begin
							tx_state_reg <= cfg_reg.par_en ? T_PAR : T_STOP;
							tx_stop2_reg <= 1'b0;
						end
					end
				end
				T_PAR: begin
					if (fall_en) begin
						tx_state_reg <= T_STOP;
						tx_stop2_reg <= 1'b0;
					end
				end
				T_STOP: begin
					if (fall_en && cfg_reg.stop2 && !tx_stop2_reg) begin
						tx_stop2_reg <= 1'b1;
					end else if (tx_load) begin
						tx_state_reg <= T_START;
					end else if (tx_done) begin
						tx_state_reg <= T_IDLE;
					end
				end
				default: tx_state_reg <= T_IDLE;
			endcase
			if (tx_load) begin
				tx_word_reg <= buf_reg;
			end
		end
	end

	// Line output; receive mode forces a high level
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			line_reg <= 1'b1;
		end else begin
			line_reg <= dir_rx_reg ? 1'b1 : (tx_level ^ cfg_reg.neg);
		end
	end

	// Receive path: chosen pin, polarity removed
	assign rx_level = (rsel_reg ? serial_rx_line1 : serial_rx_line0) ^ cfg_reg.neg;
	assign rx_restart = en_reg && dir_rx_reg && rx_state_reg == R_IDLE && !rx_level;
	assign rx_xfer = (rx_state_reg == R_XFER) && fall_en;
	assign rx_done = (rx_state_reg == R_STOP) && rise_en;

	uts_rx_align u_align (
		.raw(rx_sr_reg),
		.par_bit(rx_par_reg),
		.cfg(cfg_reg),
		.word(rx_word),
		.par_err(rx_par_err)
	);

	// Receive sequencer; restart aligns rising edges to bit centres
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_state_reg <= R_IDLE;
			rx_sr_reg <= 8'h00;
			rx_idx_reg <= 4'h0;
			rx_par_reg <= 1'b0;
			rx_bad_start_reg <= 1'b0;
		end else if (!en_reg || !dir_rx_reg) begin
			rx_state_reg <= R_IDLE;
		end else begin
			case (rx_state_reg)
				R_IDLE: begin
					if (rx_restart) begin
						rx_state_reg <= R_START;
						rx_idx_reg <= 4'h0;
					end
				end
				R_START: begin
					if (rise_en) begin
						rx_bad_start_reg <= rx_level;
						rx_state_reg <= R_DATA;
					end
				end
				R_DATA: begin
					if (rise_en) begin
						rx_sr_reg <= cfg_reg.msb_first ? {rx_sr_reg[6:0], rx_level} :
							{rx_level, rx_sr_reg[7:1]};
						rx_idx_reg <= rx_idx_reg + 4'h1;
						if (rx_idx_reg == nbits - 4'h1) begin
							rx_state_reg <= cfg_reg.par_en ? R_PAR : R_XFER;
						end
					end
				end
				R_PAR: begin
					if (rise_en) begin
						rx_par_reg <= rx_level;
						rx_state_reg <= R_XFER;
					end
				end
				R_XFER: begin
					if (fall_en) begin
						rx_state_reg <= R_STOP;
					end
				end
				R_STOP: begin
					if (rise_en) begin
						rx_state_reg <= R_IDLE;
					end
				end
				default: rx_state_reg <= R_IDLE;
			endcase
		end
	end

	// Shared buffer: software fills in transmit, receiver in receive
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			buf_reg <= 8'h00;
		end else if (rx_xfer) begin
			buf_reg <= rx_word;
		end else if (wr_buf && !dir_rx_reg) begin
			buf_reg <= wb_req.dat[7:0];
		end
	end

	// Full flag: a set wins over load or status clear
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ful_reg <= 1'b0;
		end else if (wr_buf && !dir_rx_reg) begin
			ful_reg <= 1'b1;
		end else if (tx_load || wr_stat) begin
			ful_reg <= 1'b0;
		end
	end

	// Unread word marker survives disable so overrun still shows
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			unread_reg <= 1'b0;
		end else if (rx_xfer) begin
			unread_reg <= 1'b1;
		end else if (rd && wb_req.adr == UTS_OFS_BUF) begin
			unread_reg <= 1'b0;
		end
	end

	// Error flags: updates win over a status write
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			fer_reg <= 1'b0;
			per_reg <= 1'b0;
			oer_reg <= 1'b0;
		end else begin
			if (rx_done) begin
				fer_reg <= rx_bad_start_reg || !rx_level;
				per_reg <= rx_par_err;
			end else if (wr_stat) begin
				fer_reg <= 1'b0;
				per_reg <= 1'b0;
			end
			if (rx_xfer && unread_reg) begin
				oer_reg <= 1'b1;
			end else if (wr_stat) begin
				oer_reg <= 1'b0;
			end
		end
	end

	// One-cycle interrupt request pulse
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= tx_irq || rx_done;
		end
	end

	assign wb_ack = ack_reg;
	assign wb_dat_o = dat_reg;
	assign serial_tx_line = line_reg;
	assign serial_irq = irq_reg;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	// Checks on the guarded behaviour
	rx_line_high_a: assert property (dir_rx_reg |=> serial_tx_line)
		else $error("transmit line not high in receive mode");
	start_irq_a: assert property (tx_state_reg == T_ARM && fall_en && en_reg && !dir_rx_reg
		|=> serial_irq && tx_state_reg == T_START)
		else $error("no interrupt with start bit");
	full_set_a: assert property (wr_buf && !dir_rx_reg |=> ful_reg)
		else $error("buffer write did not set full");
	tx_stop_end_a: assert property (tx_done && en_reg && !dir_rx_reg && !wr_ctrl
		|=> !en_reg ##1 tx_state_reg == T_IDLE)
		else $error("empty buffer did not end transmission");
	upper_zero_a: assert property (rx_xfer
		|=> (buf_reg & ~uts_data_mask($past(cfg_reg.len))) == 8'h00)
		else $error("upper buffer bits not zero");
	overrun_set_a: assert property (rx_xfer && unread_reg |=> oer_reg)
		else $error("overrun not flagged");
	status_clear_a: assert property (wr_stat && !rx_done && !rx_xfer && dir_rx_reg
		|=> !fer_reg && !oer_reg && !per_reg && !ful_reg)
		else $error("status write did not clear flags");
	idle_level_a: assert property (tx_state_reg == T_IDLE && !dir_rx_reg
		|=> serial_tx_line == !$past(cfg_reg.neg))
		else $error("idle line not at stop level");
	rx_irq_a: assert property (rx_xfer ##[1:300] rx_done |=> serial_irq)
		else $error("no interrupt after receive");
	tx_frame_c: cover property (tx_load ##[1:1000] tx_done);
	tx_chain_c: cover property (tx_state_reg == T_STOP && tx_load);
	rx_frame_c: cover property (rx_done && fer_reg == 1'b0);
	rx_overrun_c: cover property (rx_xfer && unread_reg);
endmodule
`default_nettype wire

/* File: dv/uts_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module uts_peer #(
	parameter int P = 8
) (
	input wire logic core_clk,
	input wire logic serial_tx_line,
	output logic rx_line
);
	// Line rests at the mark level between frames
	initial rx_line = 1'b1;

	// One bit held for a full period, changed just after an edge
	task automatic drive(input logic b);
		@(posedge core_clk);
		rx_line <= b;
		repeat (P - 1) @(posedge core_clk);
	endtask

	// Remote transmitter; bad breaks parity, or the stop bit without parity
	task automatic send(input logic [7:0] d, input int nb, input int par, input bit msb,
		input bit bad);
		logic p;
		p = ^(d & (8'hFF >> (8 - nb))) ^ (par == 2);
		drive(1'b0);
		for (int i = 0; i < nb; i++) begin
			drive(msb ? d[nb - 1 - i] : d[i]);
		end
		if (par != 0) begin
			drive(p ^ bad);
		end
		drive(~(bad && par == 0));
		rx_line <= 1'b1;
	endtask

	// Remote receiver, samples each bit at its centre
	task automatic recv(input int nb, input bit msb, output logic [7:0] d, output logic stop_ok);
		int w;
		d = 8'h00;
		w = 0;
		while (serial_tx_line !== 1'b0 && w < 4000) begin
			@(posedge core_clk);
			w++;
		end
		repeat (P / 2) @(posedge core_clk);
		for (int i = 0; i < nb; i++) begin
			repeat (P) @(posedge core_clk);
			d[msb ? nb - 1 - i : i] = serial_tx_line;
		end
		repeat (P) @(posedge core_clk);
		stop_ok = serial_tx_line;
	endtask
endmodule
`default_nettype wire

/* File: dv/uart_tx_rx_sequencer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module uart_tx_rx_sequencer_tb import uts_pkg::*; ;
	logic core_clk;
	logic rst_b;
	uts_wb_req_type wb_req;
	logic wb_ack;
	logic [31:0] wb_dat_o;
	logic serial_tx_line;
	logic serial_irq;
	logic peer_rx;
	logic pin_sel;
	int n_mismatch = 0;
	int compares = 0;
	int cycles = 0;
	// Receive cases: mode, sent data, expected word and error flags
	localparam logic [7:0] C_MODE[5] = '{8'h05, 8'h0D, 8'h43, 8'h02, 8'h00};
	localparam logic [7:0] C_DATA[5] = '{8'hD3, 8'hAA, 8'hFB, 8'hE5, 8'hC4};
	localparam logic [7:0] C_WORD[5] = '{8'h53, 8'h2A, 8'h1B, 8'h25, 8'hC4};
	localparam logic [3:0] C_STAT[5] = '{4'h0, 4'h4, 4'h0, 4'h1, 4'h0};
	localparam int C_NB[5] = '{7, 7, 5, 6, 8};
	localparam int C_PAR[5] = '{1, 2, 0, 0, 0};

	uts_top u_uts_top (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.wb_req(wb_req),
		.wb_ack(wb_ack),
		.wb_dat_o(wb_dat_o),
		.serial_rx_line0(pin_sel ? 1'b1 : peer_rx),
		.serial_rx_line1(pin_sel ? peer_rx : 1'b1),
		.serial_tx_line(serial_tx_line),
		.serial_irq(serial_irq)
	);

	uts_peer #(.P(8)) u_uts_peer (
		.core_clk(core_clk),
		.serial_tx_line(serial_tx_line),
		.rx_line(peer_rx)
	);

	// 200 MHz clock
	always #2.5 core_clk = ~core_clk;

	// Hang guard
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_mismatch++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Holds the request until ack is sampled, then releases it
	task automatic wait_ack();
		@(posedge core_clk);
		while (wb_ack !== 1'b1) @(posedge core_clk);
		wb_req <= '0;
	endtask

	task automatic wb_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: 1'b1, sel: 4'hF, adr: a, dat: d};
		wait_ack();
	endtask

	task automatic wb_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: 1'b0, sel: 4'hF, adr: a, dat: 32'h0};
		wait_ack();
		d = wb_dat_o;
	endtask

	task automatic wait_irq();
		int n;
		n = 0;
		@(posedge core_clk);
		while (serial_irq !== 1'b1 && n < 2000) begin
			@(posedge core_clk);
			n++;
		end
		chk("irq", 32'h1, {31'h0, n < 2000});
	endtask

	// One received frame, transmit line checked once 20 cycles in
	task automatic rx_frame(input logic [7:0] d, input int nb, input int par, input bit msb,
		input bit bad);
		fork
			u_uts_peer.send(d, nb, par, msb, bad);
			wait_irq();
			begin
				repeat (20) @(posedge core_clk);
				chk("tx high in rx", 32'h1, serial_tx_line);
			end
		join
	endtask

	initial begin
		logic [31:0] r;
		logic [7:0] b, b2;
		logic s, s2;
		core_clk = 1'b0;
		rst_b = 1'b0;
		wb_req = '0;
		pin_sel = 1'b0;
		repeat (20) @(posedge core_clk);
		rst_b <= 1'b1;
		@(posedge core_clk);
		chk("tx idle", 32'h1, serial_tx_line);
		wb_read(UTS_OFS_STAT, r);
		chk("stat reset", 32'h0, r);
		wb_read(8'h3C, r);
		chk("unmapped", 32'h0, r);
		wb_write(UTS_OFS_BAUD, 32'h7);
		// Single 8-bit frame, buffer not refilled
		wb_write(UTS_OFS_MODE0, 32'h0);
		wb_write(UTS_OFS_MODE1, 32'h0);
		wb_write(UTS_OFS_BUF, 32'hA5);
		wb_read(UTS_OFS_STAT, r);
		chk("full set", 32'h8, r);
		fork
			u_uts_peer.recv(8, 1'b0, b, s);
			begin
				wb_write(UTS_OFS_CTRL, 32'h1);
				wait_irq();
			end
		join
		chk("tx word", 32'hA5, b);
		chk("tx stop", 32'h1, s);
		wait_irq();
		wb_read(UTS_OFS_CTRL, r);
		chk("enable cleared", 32'h0, r);
		wb_read(UTS_OFS_STAT, r);
		chk("full clear", 32'h0, r);
		// Two 5-bit MSB-first frames, second word queued on the start interrupt
		wb_write(UTS_OFS_MODE1, 32'h43);
		wb_write(UTS_OFS_BUF, 32'h16);
		fork
			begin
				u_uts_peer.recv(5, 1'b1, b, s);
				u_uts_peer.recv(5, 1'b1, b2, s2);
			end
			begin
				wb_write(UTS_OFS_CTRL, 32'h1);
				wait_irq();
				wb_write(UTS_OFS_BUF, 32'h09);
				wb_read(UTS_OFS_STAT, r);
				chk("full queued", 32'h8, r);
				wait_irq();
			end
		join
		chk("tx first", 32'h16, b);
		chk("tx second", 32'h09, b2);
		chk("tx stops", 32'h1, s & s2);
		wait_irq();
		wb_read(UTS_OFS_CTRL, r);
		chk("enable cleared 2", 32'h0, r);
		// Receive formats, pins and error flags
		for (int i = 0; i < 5; i++) begin
			wb_write(UTS_OFS_CTRL, 32'h0);
			pin_sel <= i % 2;
			wb_write(UTS_OFS_MODE1, {24'h0, C_MODE[i]});
			wb_write(UTS_OFS_MODE0, (i % 2) << UTS_RSEL_BIT);
			wb_write(UTS_OFS_MODE0, ((i % 2) << UTS_RSEL_BIT) | 32'h1);
			wb_write(UTS_OFS_CTRL, 32'h1);
			rx_frame(C_DATA[i], C_NB[i], C_PAR[i], i == 2, C_STAT[i] != 4'h0);
			wb_read(UTS_OFS_BUF, r);
			chk("rx word", {24'h0, C_WORD[i]}, r);
			wb_read(UTS_OFS_STAT, r);
			chk("rx flags", {28'h0, C_STAT[i]}, r);
		end
		// Unread words: overrun, continuous reception, status clear, end-of-frame disable
		rx_frame(8'h11, 8, 0, 1'b0, 1'b0);
		rx_frame(8'h22, 8, 0, 1'b0, 1'b0);
		wb_read(UTS_OFS_STAT, r);
		chk("overrun", 32'h2, r);
		wb_read(UTS_OFS_BUF, r);
		chk("rx next", 32'h22, r);
		wb_write(UTS_OFS_STAT, 32'h0);
		wb_read(UTS_OFS_STAT, r);
		chk("stat cleared", 32'h0, r);
		rx_frame(8'h33, 8, 0, 1'b0, 1'b0);
		wb_write(UTS_OFS_CTRL, 32'h0);
		wb_write(UTS_OFS_CTRL, 32'h1);
		rx_frame(8'h44, 8, 0, 1'b0, 1'b0);
		wb_write(UTS_OFS_CTRL, 32'h0);
		wb_read(UTS_OFS_STAT, r);
		chk("overrun reenable", 32'h2, r);
		wb_read(UTS_OFS_BUF, r);
		chk("kept word", 32'h44, r);
		stop_test();
	end
endmodule
`default_nettype wire
